// File: hdl/aos_top.sv
// Analog output sequencer: FIFO, rate generators, clocking modes, AXI slave.
//
// Notes on behaviour
// - Simultaneous continuous: group held in shadow, all DACs load on clock.
// - Output clock comes from rate generator, software flag or external clock pin.
// - Initiator drives clock out; targets use the external clock input.
// - Simultaneous burst starts only on software or hardware sync.
// - In a burst, each collected group loads on rate generator pulses.
// - Burst ends after the burst-end word; next sync is awaited.
// - Sequential modes write each word straight to its DAC.
// - Sequential modes ignore group-end; clocking and sync otherwise match.
// - Two-bit channel field picks one of four outputs.
// - Group-end bit closes the current channel group.
// - Burst-end bit marks the last word of a burst.
// - 32K-sample FIFO with programmable threshold flag and DMA fill.
// - Two independent rate generators, either selectable.
// - Each generator divides its reference by a 16-bit divisor.
// - Generators may be cascaded, first clocking the second.
// - One generator spans 400 to 300K samples per second.
// - Each channel loads its 16-bit value unchanged.
// - 32-bit host accesses, DMA fill path, one shared interrupt.
`timescale 1ns/1ps
module aos_top
    import aos_pkg::*;
#(
    parameter int DEPTH = AOS_FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] dma_data,
    input  wire logic        dma_valid,
    output logic             dma_ready,
    input  wire logic        clk_in,
    input  wire logic        sync_in,
    output logic             clk_out,
    output logic [15:0]      dac_ch0,
    output logic [15:0]      dac_ch1,
    output logic [15:0]      dac_ch2,
    output logic [15:0]      dac_ch3,
    output logic [3:0]       dac_load,
    output logic             irq
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic           bvalid;
        logic [1:0]     bresp;
        logic           rvalid;
        logic [1:0]     rresp;
        logic [31:0]    rdata;
        logic [7:0]     ctrl;
        logic [15:0]    rate_a;
        logic [15:0]    rate_b;
        logic [14:0]    thresh;
        logic [2:0]     irq_stat;
        logic [2:0]     irq_mask;
        logic [2:0]     pre;
        logic [15:0]    cnt_a;
        logic [15:0]    cnt_b;
        logic [1:0]     pin_s1;
        logic [1:0]     pin_s2;
        logic [1:0]     pin_s3;
        logic [AW-1:0]  wr_ptr;
        logic [AW-1:0]  rd_ptr;
        logic [AW:0]    level;
        logic           above;
        logic [63:0]    shadow;
        logic [63:0]    dac;
        logic [3:0]     dac_load;
        aos_seq_t       st;
        logic           bend;
        logic           sw_clk;
        logic           sw_sync;
        logic           clk_out;
    } aos_state_t;

    aos_state_t     state_reg;
    aos_state_t     state_next;
    logic [19:0]    mem [DEPTH];
    logic [19:0]    head;
    logic           push;
    logic [19:0]    push_word;
    logic           wr_go;
    logic           rd_go;

    function automatic logic [31:0] aos_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Last count of a divider; small divisors are raised to the floor.
    function automatic logic [15:0] aos_reload(input logic [15:0] d);
        return (d < AOS_MIN_DIV) ? AOS_MIN_DIV - 16'h0001 : d - 16'h0001;
    endfunction

    function automatic logic aos_mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= AOS_IMASK_OFF;
    endfunction

    assign head = mem[state_reg.rd_ptr];

    always_comb begin
        aos_state_t s;
        aos_state_t n;
        logic pre_tick;
        logic tick_a;
        logic step_b;
        logic tick_b;
        logic rate_tick;
        logic out_tick;
        logic ext_clk;
        logic sync_evt;
        logic empty;
        logic full;
        logic pop;
        logic axi_push;
        logic clr;
        logic burst;
        logic [1:0] ch;
        logic [2:0] set;
        logic [2:0] w1c;
        s = state_reg;
        n = state_reg;
        pre_tick = 1'b0;
        tick_a = 1'b0;
        step_b = 1'b0;
        tick_b = 1'b0;
        rate_tick = 1'b0;
        out_tick = 1'b0;
        pop = 1'b0;
        axi_push = 1'b0;
        clr = 1'b0;
        set = 3'h0;
        w1c = 3'h0;
        ch = head[AOS_W_CH +: 2];
        burst = s.ctrl[AOS_CTRL_BRST];
        empty = s.level == '0;
        full = s.level == (AW+1)'(DEPTH);
        n.dac_load = 4'h0;
        n.sw_clk = 1'b0;
        n.sw_sync = 1'b0;

        // Pins are brought in through three flops; edges use stages two and three.
        n.pin_s1 = {clk_in, sync_in};
        n.pin_s2 = s.pin_s1;
        n.pin_s3 = s.pin_s2;
        ext_clk = s.pin_s2[1] & ~s.pin_s3[1];
        sync_evt = s.sw_sync | (s.pin_s2[0] & ~s.pin_s3[0]);

        // Reference prescaler feeds generator A, and generator B unless cascaded.
        pre_tick = s.pre == 3'(AOS_REF_DIV - 1);
        n.pre = pre_tick ? 3'h0 : s.pre + 3'h1;
        if (pre_tick) begin
            // Counting up lets a new divisor take effect at once.
            tick_a = s.cnt_a >= aos_reload(s.rate_a);
            n.cnt_a = tick_a ? 16'h0000 : s.cnt_a + 16'h0001;
        end
        step_b = s.ctrl[AOS_CTRL_CASC] ? tick_a : pre_tick;
        if (step_b) begin
            tick_b = s.cnt_b >= aos_reload(s.rate_b);
            n.cnt_b = tick_b ? 16'h0000 : s.cnt_b + 16'h0001;
        end
        rate_tick = s.ctrl[AOS_CTRL_GENB] ? tick_b : tick_a;

        if (burst) begin
            out_tick = rate_tick;
        end else begin
            case (s.ctrl[AOS_CTRL_SRC +: 2])
                AOS_SRC_RATE: out_tick = rate_tick;
                AOS_SRC_SOFT: out_tick = s.sw_clk;
                AOS_SRC_EXT:  out_tick = ext_clk;
                default:      out_tick = 1'b0;
            endcase
        end
        n.clk_out = s.ctrl[AOS_CTRL_INIT] & out_tick;

        // AXI4-Lite write: address and data are taken together.
        wr_go = s_axi_awvalid & s_axi_wvalid & ~s.bvalid;
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (wr_go) begin
            n.bvalid = 1'b1;
            n.bresp = aos_mapped(s_axi_awaddr) ? AOS_RESP_OK : AOS_RESP_ERR;
            if (s_axi_awaddr == AOS_CTRL_OFF) begin
                n.ctrl = 8'(aos_merge({24'h0, s.ctrl}, s_axi_wdata,
                                      s_axi_wstrb));
            end else if (s_axi_awaddr == AOS_CMD_OFF) begin
                if (s_axi_wstrb[0]) begin
                    n.sw_clk = s_axi_wdata[AOS_CMD_SWCLK];
                    n.sw_sync = s_axi_wdata[AOS_CMD_SWSYNC];
                    clr = s_axi_wdata[AOS_CMD_CLR];
                end
            end else if (s_axi_awaddr == AOS_RATEA_OFF) begin
                n.rate_a = 16'(aos_merge({16'h0, s.rate_a}, s_axi_wdata,
                                         s_axi_wstrb));
            end else if (s_axi_awaddr == AOS_RATEB_OFF) begin
                n.rate_b = 16'(aos_merge({16'h0, s.rate_b}, s_axi_wdata,
                                         s_axi_wstrb));
            end else if (s_axi_awaddr == AOS_THR_OFF) begin
                n.thresh = 15'(aos_merge({17'h0, s.thresh}, s_axi_wdata,
                                         s_axi_wstrb));
            end else if (s_axi_awaddr == AOS_DATA_OFF) begin
                axi_push = 1'b1;
            end else if (s_axi_awaddr == AOS_ISTAT_OFF) begin
                w1c = s_axi_wstrb[0] ? s_axi_wdata[2:0] : 3'h0;
            end else if (s_axi_awaddr == AOS_IMASK_OFF) begin
                if (s_axi_wstrb[0]) begin
                    n.irq_mask = s_axi_wdata[2:0];
                end
            end
        end

        // AXI4-Lite read.
        rd_go = s_axi_arvalid & ~s.rvalid;
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (rd_go) begin
            n.rvalid = 1'b1;
            n.rresp = aos_mapped(s_axi_araddr) ? AOS_RESP_OK : AOS_RESP_ERR;
            n.rdata = 32'h0;
            if (s_axi_araddr == AOS_CTRL_OFF) begin
                n.rdata = {24'h0, s.ctrl};
            end else if (s_axi_araddr == AOS_RATEA_OFF) begin
                n.rdata = {16'h0, s.rate_a};
            end else if (s_axi_araddr == AOS_RATEB_OFF) begin
                n.rdata = {16'h0, s.rate_b};
            end else if (s_axi_araddr == AOS_THR_OFF) begin
                n.rdata = {17'h0, s.thresh};
            end else if (s_axi_araddr == AOS_STAT_OFF) begin
                n.rdata = {12'h0, s.st != AOS_ST_IDLE, s.above, full, empty,
                           16'(s.level)};
            end else if (s_axi_araddr == AOS_ISTAT_OFF) begin
                n.rdata = {29'h0, s.irq_stat};
            end else if (s_axi_araddr == AOS_IMASK_OFF) begin
                n.rdata = {29'h0, s.irq_mask};
            end
        end

        // FIFO fill from the register port or the DMA engine.
        dma_ready = ~full & ~axi_push;
        push = ~full & (axi_push | dma_valid);
        push_word = axi_push ? s_axi_wdata[19:0] : dma_data[19:0];
        set[AOS_IRQ_OVF] = axi_push & full;

        // Sequencer.
        case (s.st)
            AOS_ST_IDLE: begin
                n.bend = 1'b0;
                if (!burst || sync_evt) begin
                    n.st = AOS_ST_COLLECT;
                end
            end
            AOS_ST_COLLECT: begin
                if (s.ctrl[AOS_CTRL_SEQ]) begin
                    if (!empty && out_tick) begin
                        pop = 1'b1;
                        n.dac[16*ch +: 16] = head[15:0];
                        n.dac_load[ch] = 1'b1;
                        if (burst && head[AOS_W_BEND]) begin
                            n.st = AOS_ST_IDLE;
                            set[AOS_IRQ_BDN] = 1'b1;
                        end
                    end
                end else if (!empty) begin
                    pop = 1'b1;
                    n.shadow[16*ch +: 16] = head[15:0];
                    n.bend = s.bend | head[AOS_W_BEND];
                    if (head[AOS_W_GEND] || head[AOS_W_BEND]) begin
                        n.st = AOS_ST_READY;
                    end
                end
            end
            AOS_ST_READY: begin
                if (out_tick) begin
                    n.dac = s.shadow;
                    n.dac_load = 4'hf;
                    n.st = AOS_ST_COLLECT;
                    if (burst && s.bend) begin
                        n.st = AOS_ST_IDLE;
                        set[AOS_IRQ_BDN] = 1'b1;
                    end
                end
            end
            default: n.st = AOS_ST_IDLE;
        endcase
        // Entering burst mode parks the sequencer until the next sync.
        if (!s.ctrl[AOS_CTRL_ENA] ||
            (n.ctrl[AOS_CTRL_BRST] && !burst)) begin
            n.st = AOS_ST_IDLE;
            n.dac_load = 4'h0;
            pop = 1'b0;
        end

        if (push) begin
            n.wr_ptr = s.wr_ptr + AW'(1);
        end
        if (pop) begin
            n.rd_ptr = s.rd_ptr + AW'(1);
        end
        n.level = s.level + (AW+1)'(push) - (AW+1)'(pop);
        if (clr) begin
            n.wr_ptr = '0;
            n.rd_ptr = '0;
            n.level = '0;
            n.st = AOS_ST_IDLE;
            push = 1'b0;
        end

        // Threshold event when the fill drops to or below the threshold.
        n.above = s.level > (AW+1)'(s.thresh);
        set[AOS_IRQ_THR] = s.above & ~n.above;
        n.irq_stat = (s.irq_stat & ~w1c) | set;

        state_next = n;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
            state_reg.ctrl <= AOS_CTRL_RST;
            state_reg.rate_a <= AOS_RATE_RST;
            state_reg.rate_b <= AOS_RATE_RST;
            state_reg.thresh <= AOS_THR_RST;
            state_reg.st <= AOS_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[state_reg.wr_ptr] <= push_word;
        end
    end

    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rresp = state_reg.rresp;
    assign s_axi_rdata = state_reg.rdata;
    assign clk_out = state_reg.clk_out;
    assign dac_ch0 = state_reg.dac[15:0];
    assign dac_ch1 = state_reg.dac[31:16];
    assign dac_ch2 = state_reg.dac[47:32];
    assign dac_ch3 = state_reg.dac[63:48];
    assign dac_load = state_reg.dac_load;
    // One shared interrupt line for all unmasked events.
    assign irq = |(state_reg.irq_stat & state_reg.irq_mask);
endmodule

// File: hdl/aos_pkg.sv
// Shared constants and types of the analog output sequencer.
package aos_pkg;
    localparam int unsigned AOS_CLK_HZ  = 125_000_000;
    localparam int unsigned AOS_REF_HZ  = 25_000_000;
    localparam int unsigned AOS_MAX_SPS = 300_000;
    localparam int unsigned AOS_MIN_SPS = 400;
    localparam int unsigned AOS_REF_DIV = AOS_CLK_HZ / AOS_REF_HZ;
    // Smallest divisor that keeps one generator at or below the top rate.
    localparam logic [15:0] AOS_MIN_DIV =
        16'((AOS_REF_HZ + AOS_MAX_SPS - 1) / AOS_MAX_SPS);
    localparam int unsigned AOS_FIFO_DEPTH = 32768;

    localparam logic [7:0] AOS_CTRL_OFF  = 8'h00;
    localparam logic [7:0] AOS_CMD_OFF   = 8'h04;
    localparam logic [7:0] AOS_RATEA_OFF = 8'h08;
    localparam logic [7:0] AOS_RATEB_OFF = 8'h0c;
    localparam logic [7:0] AOS_THR_OFF   = 8'h10;
    localparam logic [7:0] AOS_DATA_OFF  = 8'h14;
    localparam logic [7:0] AOS_STAT_OFF  = 8'h18;
    localparam logic [7:0] AOS_ISTAT_OFF = 8'h1c;
    localparam logic [7:0] AOS_IMASK_OFF = 8'h20;

    localparam int AOS_CTRL_ENA  = 0;
    localparam int AOS_CTRL_BRST = 1;
    localparam int AOS_CTRL_SEQ  = 2;
    localparam int AOS_CTRL_SRC  = 3;
    localparam int AOS_CTRL_INIT = 5;
    localparam int AOS_CTRL_CASC = 6;
    localparam int AOS_CTRL_GENB = 7;

    localparam int AOS_CMD_SWCLK  = 0;
    localparam int AOS_CMD_SWSYNC = 1;
    localparam int AOS_CMD_CLR    = 2;

    localparam int AOS_W_CH   = 16;
    localparam int AOS_W_GEND = 18;
    localparam int AOS_W_BEND = 19;

    localparam int AOS_IRQ_THR = 0;
    localparam int AOS_IRQ_BDN = 1;
    localparam int AOS_IRQ_OVF = 2;

    localparam logic [1:0] AOS_SRC_RATE = 2'h0;
    localparam logic [1:0] AOS_SRC_SOFT = 2'h1;
    localparam logic [1:0] AOS_SRC_EXT  = 2'h2;

    localparam logic [7:0]  AOS_CTRL_RST = 8'h00;
    localparam logic [15:0] AOS_RATE_RST = 16'hffff;
    localparam logic [14:0] AOS_THR_RST  = 15'h0000;
    localparam logic [1:0]  AOS_RESP_OK  = 2'h0;
    localparam logic [1:0]  AOS_RESP_ERR = 2'h2;

    typedef enum logic [1:0] {
        AOS_ST_IDLE,
        AOS_ST_COLLECT,
        AOS_ST_READY
    } aos_seq_t;
endpackage

// File: tb/aos_dma_src.sv
// DMA word source that stands in for host memory behind the bus master.
`timescale 1ns/1ps
module aos_dma_src (
    input  wire logic        clk,
    input  wire logic        dma_ready,
    output logic [31:0]      dma_data,
    output logic             dma_valid
);
    int lag = 0;
    int fails = 0;

    initial begin
        dma_data = 32'h0;
        dma_valid = 1'b0;
    end

    // Offers one packed word after lag idle cycles and holds it until taken.
    task automatic send(input logic [1:0] ch, input logic gend,
                        input logic bend, input logic [15:0] smp);
        int n;
        repeat (lag) @(posedge clk);
        dma_data <= {12'h000, bend, gend, ch, smp};
        dma_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dma_ready !== 1'b1 && n < 200);
        if (n >= 200) fails++;
        dma_valid <= 1'b0;
        // A released bus must not look like the word just sent.
        dma_data <= ~dma_data;
        @(posedge clk);
    endtask
endmodule

// File: tb/aos_top_assertions.sv
// Port-level assertions for the analog output sequencer.
`timescale 1ns/1ps
module aos_top_assertions
    import aos_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        dma_ready,
    input wire logic [15:0] dac_ch0,
    input wire logic [3:0]  dac_load,
    input wire logic        clk_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence wr_take;
        s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    endsequence
    sequence rd_take;
        s_axi_arready;
    endsequence

    wr_ready_a: assert property (
        s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
        else $error("write ready wrong");
    wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
        else $error("write response missing");
    resp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data missing");
    rd_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    dma_block_a: assert property (
        s_axi_awready && s_axi_awaddr == AOS_DATA_OFF |-> !dma_ready)
        else $error("dma taken during data write");
    load_shape_a: assert property (
        dac_load != 4'h0 |-> dac_load == 4'hf || $onehot(dac_load))
        else $error("bad load pattern");
    load_pulse_a: assert property (dac_load != 4'h0 |=> dac_load == 4'h0)
        else $error("load longer than a cycle");
    ch0_hold_a: assert property (!dac_load[0] |-> $stable(dac_ch0))
        else $error("channel 0 moved without load");
    clk_pulse_a: assert property (clk_out |=> !clk_out)
        else $error("clock out too long");
endmodule

bind aos_top aos_top_assertions u_chk (.clk, .resetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .dma_ready, .dac_ch0, .dac_load, .clk_out);

// File: tb/test_analog_output_sequencer.sv
// Self-checking bench for the analog output sequencer.
`timescale 1ns/1ps
module test_analog_output_sequencer;
    import aos_pkg::*;
    logic        clk, resetn, clk_in, sync_in, clk_out, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, dma_data;
    logic [3:0]  s_axi_wstrb, dac_load;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, dma_valid, dma_ready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] dac_ch0, dac_ch1, dac_ch2, dac_ch3;
    int          mismatches = 0, tests_run = 0, loads = 0, pulses = 0;
    int          gap, base;
    time         t_hit = 0;

    aos_top #(.DEPTH(16)) u_dut (.clk, .resetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dma_data,
        .dma_valid, .dma_ready, .clk_in, .sync_in, .clk_out, .dac_ch0,
        .dac_ch1, .dac_ch2, .dac_ch3, .dac_load, .irq);
    aos_dma_src u_dma (.clk, .dma_ready, .dma_data, .dma_valid);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (dac_load !== 4'h0) loads++;
        if (clk_out === 1'b1) pulses++;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk4(input logic [15:0] a, b, c, d);
        chk("dac_ch0", 32'(a), 32'(dac_ch0));
        chk("dac_ch1", 32'(b), 32'(dac_ch1));
        chk("dac_ch2", 32'(c), 32'(dac_ch2));
        chk("dac_ch3", 32'(d), 32'(dac_ch3));
    endtask

    task automatic conclude();
        if (mismatches == 0 && tests_run > 0 && u_dma.fails == 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = AOS_RESP_OK);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s_axi_awready !== 1'b1 && n < 50);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (s_axi_bvalid !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        tmo(n, 50);
        chk("bresp", 32'(er), 32'(s_axi_bresp));
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] e, input logic [1:0] er = AOS_RESP_OK);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 50);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        tmo(n, 50);
        chk(nm, e, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_load(input logic [3:0] e, input int lim);
        int n;
        n = 0;
        while (dac_load === 4'h0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        tmo(n, lim);
        gap = int'(($time - t_hit) / 8);
        t_hit = $time;
        chk("dac_load", 32'(e), 32'(dac_load));
        @(posedge clk);
    endtask

    initial begin
        {resetn, clk_in, sync_in, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd("ctrl", AOS_CTRL_OFF, 32'h0);
        rd("rate_a", AOS_RATEA_OFF, 32'h0000_ffff);
        rd("thr", AOS_THR_OFF, 32'h0);
        wr(8'h24, 32'h1, AOS_RESP_ERR);
        wr(8'h02, 32'h1, AOS_RESP_ERR);
        rd("unmapped", 8'h24, 32'h0, AOS_RESP_ERR);
        wr(AOS_CTRL_OFF, 32'h29);
        u_dma.send(2'h3, 1'b0, 1'b0, 16'hfedc);
        u_dma.send(2'h1, 1'b0, 1'b0, 16'h8001);
        u_dma.send(2'h0, 1'b0, 1'b0, 16'h0000);
        u_dma.send(2'h2, 1'b1, 1'b0, 16'h7fff);
        repeat (4) @(posedge clk);
        chk("early loads", 32'h0, 32'(loads));
        wr(AOS_CMD_OFF, 32'h1);
        wait_load(4'hf, 20);
        chk4(16'h0000, 16'h8001, 16'h7fff, 16'hfedc);
        wr(AOS_CTRL_OFF, 32'h0d);
        u_dma.lag = 3;
        u_dma.send(2'h2, 1'b1, 1'b0, 16'h1234);
        u_dma.send(2'h1, 1'b0, 1'b0, 16'habcd);
        chk("clk_out", 32'h1, 32'(pulses));
        wr(AOS_CMD_OFF, 32'h1);
        wait_load(4'h4, 20);
        chk("dac_ch2", 32'h1234, 32'(dac_ch2));
        wr(AOS_CMD_OFF, 32'h1);
        wait_load(4'h2, 20);
        chk("dac_ch1", 32'habcd, 32'(dac_ch1));
        wr(AOS_CTRL_OFF, 32'h15);
        u_dma.send(2'h3, 1'b0, 1'b0, 16'h5a5a);
        clk_in <= 1'b1;
        wait_load(4'h8, 20);
        clk_in <= 1'b0;
        chk("dac_ch3", 32'h5a5a, 32'(dac_ch3));
        u_dma.lag = 0;
        wr(AOS_RATEB_OFF, 32'h0010);
        wr(AOS_CTRL_OFF, 32'h85);
        u_dma.send(2'h0, 1'b0, 1'b0, 16'h0f0f);
        u_dma.send(2'h1, 1'b0, 1'b0, 16'hf0f0);
        wait_load(4'h1, 1000);
        wait_load(4'h2, 1000);
        chk("tick gap", 32'd420, 32'(gap));
        wr(AOS_RATEA_OFF, 32'h0054);
        wr(AOS_CTRL_OFF, 32'hc5);
        u_dma.send(2'h0, 1'b0, 1'b0, 16'h1357);
        u_dma.send(2'h1, 1'b0, 1'b0, 16'h2468);
        wait_load(4'h1, 40000);
        wait_load(4'h2, 40000);
        chk("cascade gap", 32'd35280, 32'(gap));
        chk("dac_ch1", 32'h2468, 32'(dac_ch1));
        wr(AOS_ISTAT_OFF, 32'h7);
        wr(AOS_IMASK_OFF, 32'h2);
        wr(AOS_CTRL_OFF, 32'h03);
        for (int i = 0; i < 8; i++)
            u_dma.send(i[1:0], i == 3, i == 7, 16'(i * 16'h1111));
        base = loads;
        repeat (900) @(posedge clk);
        chk("loads before sync", 32'(base), 32'(loads));
        sync_in <= 1'b1;
        wait_load(4'hf, 1000);
        sync_in <= 1'b0;
        chk4(16'h0000, 16'h1111, 16'h2222, 16'h3333);
        wait_load(4'hf, 1000);
        chk("burst gap", 32'd420, 32'(gap));
        chk4(16'h4444, 16'h5555, 16'h6666, 16'h7777);
        base = loads;
        repeat (900) @(posedge clk);
        chk("loads after burst", 32'(base), 32'(loads));
        chk("irq", 32'h1, 32'(irq));
        rd("istat", AOS_ISTAT_OFF, 32'h3);
        u_dma.send(2'h0, 1'b1, 1'b1, 16'hbeef);
        wr(AOS_CMD_OFF, 32'h2);
        wait_load(4'hf, 1000);
        chk4(16'hbeef, 16'h5555, 16'h6666, 16'h7777);
        wr(AOS_ISTAT_OFF, 32'h2);
        chk("irq cleared", 32'h0, 32'(irq));
        wr(AOS_CTRL_OFF, 32'h0);
        for (int i = 0; i < 17; i++)
            wr(AOS_DATA_OFF, 32'(i));
        chk("dma blocked", 32'h0, 32'(dma_ready));
        rd("stat full", AOS_STAT_OFF, 32'h0006_0010);
        rd("istat ovf", AOS_ISTAT_OFF, 32'h5);
        wr(AOS_CMD_OFF, 32'h4);
        rd("stat empty", AOS_STAT_OFF, 32'h0001_0000);
        conclude();
    end
endmodule
